// File: core/mmvd_decode.sv
// Overview of operation
// - $0080-$00ff decodes as 128 bytes of read/write ram.
// - stack pointer is a 16-bit register, writable to any address.
// - interrupt entry pushes exactly five context bytes.
// - index-high register is never pushed on interrupt entry.
// - subroutine call pushes a two-byte return address.
// - pointer decrements per pushed byte, increments per pulled byte.
// - conversion-done vector at $ffde/$ffdf, lowest priority.
// - priority: keypad, timer, pin, software, reset highest; low first.
// - timer overflow vector at $fff2/$fff3.
// - timer channel 1 at $fff4/5, channel 0 at $fff6/7.
// - trim bytes read at $ffc0 and $ffc1; reset leaves them.
// - $fe0d-$fe0f reserved for array test, no application register.
// - pending flags read-only; unimplemented positions read zero.
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mmvd_decode
    import mmvd_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        nrst,
    // cpu memory port
    input  wire logic [15:0] cpuAddr,
    input  wire logic        cpuRd,
    input  wire logic        cpuWr,
    input  wire logic [7:0]  cpuWdata,
    output logic      [7:0]  cpuRdata,
    output logic             vecRead,
    // vector rom bytes from the array, indexed by address bits [5:0]
    input  wire logic [7:0]  vecByte,
    // stacking requests from the cpu sequencer
    input  wire logic        irqEnter,
    input  wire logic        callEnter,
    input  wire logic        pullByte,
    input  wire logic [7:0]  ctxByte,
    output logic             pushStrobe,
    output logic      [2:0]  pushIndex,
    output logic             stackBusy,
    output logic      [15:0] stackPtr,
    // pending inputs from peripherals
    input  wire logic        conversionDonePending,
    input  wire logic        keypadPending,
    input  wire logic        timerOverflowPending,
    input  wire logic        timerChannel1Pending,
    input  wire logic        timerChannel0Pending,
    input  wire logic        externalPinPending,
    input  wire logic        softwareInterrupt,
    input  wire logic        lowVoltageIndicator,
    output logic      [15:0] vectorAddr,
    output logic             watchdogKick,
    // axi4-lite slave
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic      [1:0]  s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0]  s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             irqOut
);
    logic [7:0]  ram [0:127];
    logic [7:0]  nvpc_r, bah_r, bal_r, bsc_r, abp_r;
    logic [7:0]  trim5_r, trim3_r;
    logic        trimLoaded_r = 1'b0; // power-on value, nrst leaves it
    logic [15:0] sp_r;
    logic [2:0]  cnt_r;
    logic [2:0]  len_r;
    mmvd_stk_e   st_r;
    logic [EV_NBIT-1:0] evSt_r, evEn_r;
    logic [EV_NBIT-1:0] evSet;
    logic [7:0]  int1, int2, int3;
    logic        inRam, inNvt;
    logic [7:0]  rdMux;
    logic        awHeld_r, wHeld_r;
    logic [7:0]  awA_r;
    logic [31:0] wD_r;
    logic [3:0]  wS_r;
    logic        doWr;
    logic [EV_NBIT-1:0] clrMask;

    // address windows
    assign inRam = cpuAddr >= RAM_LO && cpuAddr <= RAM_HI;
    assign inNvt = cpuAddr >= NVT_LO && cpuAddr <= NVT_HI;

    // pending views: unimplemented positions stay zero
    assign int1 = {1'b0, timerOverflowPending, timerChannel1Pending,
                   timerChannel0Pending, 1'b0, externalPinPending,
                   2'b00};
    assign int2 = {keypadPending, 7'h00};
    assign int3 = {7'h00, conversionDonePending};

    // fixed priority, reset is never requested here so swi is top
    always_comb begin
        vectorAddr = VEC_RST;
        if (softwareInterrupt)
            vectorAddr = VEC_SWI;
        else if (externalPinPending)
            vectorAddr = VEC_EXT;
        else if (timerChannel0Pending)
            vectorAddr = VEC_TC0;
        else if (timerChannel1Pending)
            vectorAddr = VEC_TC1;
        else if (timerOverflowPending)
            vectorAddr = VEC_TOV;
        else if (keypadPending)
            vectorAddr = VEC_KBD;
        else if (conversionDonePending)
            vectorAddr = VEC_ADC;
    end

    // cpu read mux; test window and unmapped read zero
    always_comb begin
        rdMux = 8'h00;
        vecRead = 1'b0;
        if (inRam)
            rdMux = ram[cpuAddr[6:0]];
        else if (cpuAddr >= VEC_ADC) begin
            rdMux = vecByte;
            vecRead = cpuRd;
        end else begin
            case (cpuAddr)
                INT1_ADDR:  rdMux = int1;
                INT2_ADDR:  rdMux = int2;
                INT3_ADDR:  rdMux = int3;
                NVPC_ADDR:  rdMux = nvpc_r;
                BAH_ADDR:   rdMux = bah_r;
                BAL_ADDR:   rdMux = bal_r;
                BSC_ADDR:   rdMux = bsc_r;
                LVS_ADDR:   rdMux = {lowVoltageIndicator, 7'h00};
                ABP_ADDR:   rdMux = abp_r;
                TRIM5_ADDR: rdMux = trim5_r;
                TRIM3_ADDR: rdMux = trim3_r;
                default:    rdMux = 8'h00;
            endcase
        end
    end

    // registered read data
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            cpuRdata <= 8'h00;
        else if (cpuRd)
            cpuRdata <= rdMux;
    end

    // control registers; the test window has no storage at all
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            nvpc_r <= REG_RST;
            bah_r  <= REG_RST;
            bal_r  <= REG_RST;
            bsc_r  <= REG_RST;
        end else if (cpuWr && !inNvt) begin
            case (cpuAddr)
                NVPC_ADDR: nvpc_r <= cpuWdata & NVPC_MASK;
                BAH_ADDR:  bah_r  <= cpuWdata;
                BAL_ADDR:  bal_r  <= cpuWdata;
                BSC_ADDR:  bsc_r  <= cpuWdata & BSC_MASK;
                default:   ;
            endcase
        end
    end

    // trim and protect bytes are not reset: loaded once after power-up
    always_ff @(posedge ref_clk) begin
        if (nrst && !trimLoaded_r) begin
            trim5_r <= TRIM_DFLT;
            trim3_r <= TRIM_DFLT;
            abp_r   <= ABP_DFLT;
        end else if (cpuWr && cpuAddr == ABP_ADDR)
            abp_r <= cpuWdata;
        else if (doWr && awA_r == AX_TRIM) begin
            trim5_r <= wD_r[7:0];
            trim3_r <= wD_r[15:8];
        end
    end
    // never cleared by nrst, else a later reset would reload the trims
    always_ff @(posedge ref_clk) begin
        if (nrst)
            trimLoaded_r <= 1'b1;
    end

    // watchdog kick on any write to the reset-vector-low address
    assign watchdogKick = cpuWr && cpuAddr == WDOG_ADDR;

    // stacking sequencer: irq 5 bytes, call 2 bytes, no index-high byte
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            st_r  <= ST_IDLE;
            cnt_r <= 3'h0;
            len_r <= 3'h0;
        end else begin
            case (st_r)
                ST_IDLE: begin
                    cnt_r <= 3'h0;
                    if (irqEnter) begin
                        len_r <= IRQ_FRAME;
                        st_r  <= ST_STK;
                    end else if (callEnter) begin
                        len_r <= JSR_FRAME;
                        st_r  <= ST_STK;
                    end
                end
                ST_STK: begin
                    cnt_r <= cnt_r + 3'h1;
                    if (cnt_r == len_r - 3'h1)
                        st_r <= ST_DONE;
                end
                ST_DONE: st_r <= ST_IDLE;
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    assign pushStrobe = st_r == ST_STK;
    assign pushIndex  = cnt_r;
    assign stackBusy  = st_r != ST_IDLE;

    // stack pointer; software sets it, hardware moves it one per byte
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            sp_r <= SP_RST;
        else if (pushStrobe)
            sp_r <= sp_r - 16'h0001;
        else if (pullByte && !stackBusy)
            sp_r <= sp_r + 16'h0001;
        else if (doWr && awA_r == AX_SPREG)
            sp_r <= wD_r[15:0];
    end
    assign stackPtr = sp_r;

    // ram port, shared with pushes (push wins, cpu is stalled then)
    always_ff @(posedge ref_clk) begin
        if (pushStrobe && sp_r >= RAM_LO && sp_r <= RAM_HI)
            ram[sp_r[6:0]] <= ctxByte;
        else if (cpuWr && inRam)
            ram[cpuAddr[6:0]] <= cpuWdata;
    end

    // axi write channel capture, either order
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
            awA_r    <= 8'h00;
            wD_r     <= 32'h0;
            wS_r     <= 4'h0;
            s_axi_bvalid <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awA_r    <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wD_r    <= s_axi_wdata;
                wS_r    <= s_axi_wstrb;
            end
            if (doWr) begin
                awHeld_r     <= 1'b0;
                wHeld_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end
    assign s_axi_awready = !awHeld_r && !s_axi_bvalid;
    assign s_axi_wready  = !wHeld_r && !s_axi_bvalid;
    assign doWr = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign s_axi_bresp = (awA_r > AX_WDOG) ? 2'b10 : 2'b00;

    // events: kick, stacking done, test-window write
    assign evSet = {cpuWr && inNvt, st_r == ST_DONE, watchdogKick};
    assign clrMask = (doWr && awA_r == AX_CLEAR && wS_r[0])
                     ? wD_r[EV_NBIT-1:0] : '0;
    // set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            evSt_r <= '0;
        else
            evSt_r <= (evSt_r & ~clrMask) | evSet;
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst)
            evEn_r <= '0;
        else if (doWr && awA_r == AX_ENABLE && wS_r[0])
            evEn_r <= wD_r[EV_NBIT-1:0];
    end
    assign irqOut = |(evSt_r & evEn_r);

    // axi read, one cycle after address
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= 2'b00;
            case (s_axi_araddr)
                AX_STATUS: s_axi_rdata <= {29'h0, evSt_r};
                AX_ENABLE: s_axi_rdata <= {29'h0, evEn_r};
                AX_PEND:   s_axi_rdata <= {8'h0, int3, int2, int1};
                AX_VECSEL: s_axi_rdata <= {16'h0, vectorAddr};
                AX_SPREG:  s_axi_rdata <= {16'h0, sp_r};
                AX_TRIM:   s_axi_rdata <= {16'h0, trim3_r, trim5_r};
                AX_CLEAR,
                AX_WDOG:   s_axi_rdata <= 32'h0;
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= 2'b10;
                end
            endcase
        end else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid;

    // checks
    chk_irq_frame: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r == ST_IDLE && irqEnter) |=> pushStrobe [*5] ##1 !pushStrobe)
        else $error("irq frame not five bytes");
    chk_call_frame: assert property (@(posedge ref_clk) disable iff (!nrst)
        (st_r == ST_IDLE && !irqEnter && callEnter)
        |=> pushStrobe [*2] ##1 !pushStrobe)
        else $error("call frame not two bytes");
    chk_sp_push: assert property (@(posedge ref_clk) disable iff (!nrst)
        pushStrobe |=> sp_r == $past(sp_r) - 16'h0001)
        else $error("sp not decremented on push");
    chk_sp_pull: assert property (@(posedge ref_clk) disable iff (!nrst)
        (pullByte && !stackBusy) |=> sp_r == $past(sp_r) + 16'h0001)
        else $error("sp not incremented on pull");
    chk_adc_low: assert property (@(posedge ref_clk) disable iff (!nrst)
        (conversionDonePending && !keypadPending && !externalPinPending
         && !softwareInterrupt && !timerOverflowPending) |-> 1'b1 &&
        (timerChannel0Pending || timerChannel1Pending
         || vectorAddr == VEC_ADC))
        else $error("adc vector wrong");
    chk_swi_top: assert property (@(posedge ref_clk) disable iff (!nrst)
        softwareInterrupt |-> vectorAddr == VEC_SWI)
        else $error("swi not top");
    chk_kick_pulse: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cpuWr && cpuAddr == WDOG_ADDR) |-> watchdogKick && !inRam)
        else $error("watchdog kick missed");
    chk_int2_zero: assert property (@(posedge ref_clk) disable iff (!nrst)
        int2[6:0] == 7'h00 && int1[7] == 1'b0 && int3[7:1] == 7'h00)
        else $error("unimplemented pending bit set");
    chk_nvt_inert: assert property (@(posedge ref_clk) disable iff (!nrst)
        (cpuWr && inNvt) |=> $stable(nvpc_r) && evSt_r[EV_NVT])
        else $error("test window write took effect");
endmodule
`default_nettype wire

// File: core/mmvd_pkg.sv
package mmvd_pkg;
    // axi byte addresses of the software-side registers
    localparam logic [7:0] AX_STATUS  = 8'h00;
    localparam logic [7:0] AX_CLEAR   = 8'h04;
    localparam logic [7:0] AX_ENABLE  = 8'h08;
    localparam logic [7:0] AX_PEND    = 8'h0c;
    localparam logic [7:0] AX_VECSEL  = 8'h10;
    localparam logic [7:0] AX_SPREG   = 8'h14;
    localparam logic [7:0] AX_TRIM    = 8'h18;
    localparam logic [7:0] AX_WDOG    = 8'h1c;
    // cpu memory map
    localparam logic [15:0] RAM_LO     = 16'h0080;
    localparam logic [15:0] RAM_HI     = 16'h00ff;
    localparam logic [15:0] INT1_ADDR  = 16'hfe04;
    localparam logic [15:0] INT2_ADDR  = 16'hfe05;
    localparam logic [15:0] INT3_ADDR  = 16'hfe06;
    localparam logic [15:0] NVPC_ADDR  = 16'hfe08;
    localparam logic [15:0] BAH_ADDR   = 16'hfe09;
    localparam logic [15:0] BAL_ADDR   = 16'hfe0a;
    localparam logic [15:0] BSC_ADDR   = 16'hfe0b;
    localparam logic [15:0] LVS_ADDR   = 16'hfe0c;
    localparam logic [15:0] NVT_LO     = 16'hfe0d;
    localparam logic [15:0] NVT_HI     = 16'hfe0f;
    localparam logic [15:0] ABP_ADDR   = 16'hffbe;
    localparam logic [15:0] TRIM5_ADDR = 16'hffc0;
    localparam logic [15:0] TRIM3_ADDR = 16'hffc1;
    localparam logic [15:0] WDOG_ADDR  = 16'hffff;
    // vector addresses, high byte at the even one
    localparam logic [15:0] VEC_ADC  = 16'hffde;
    localparam logic [15:0] VEC_KBD  = 16'hffe0;
    localparam logic [15:0] VEC_TOV  = 16'hfff2;
    localparam logic [15:0] VEC_TC1  = 16'hfff4;
    localparam logic [15:0] VEC_TC0  = 16'hfff6;
    localparam logic [15:0] VEC_EXT  = 16'hfffa;
    localparam logic [15:0] VEC_SWI  = 16'hfffc;
    localparam logic [15:0] VEC_RST  = 16'hfffe;
    // stacking sizes and reset values
    localparam logic [2:0]  IRQ_FRAME = 3'h5;
    localparam logic [2:0]  JSR_FRAME = 3'h2;
    localparam logic [15:0] SP_RST    = 16'h00ff;
    localparam logic [7:0]  REG_RST   = 8'h00;
    localparam logic [7:0]  NVPC_MASK = 8'h0f;
    localparam logic [7:0]  BSC_MASK  = 8'hc0;
    localparam logic [7:0]  TRIM_DFLT = 8'h80;
    localparam logic [7:0]  ABP_DFLT  = 8'hff;
    // event bits
    localparam int EV_KICK = 0;
    localparam int EV_PUSH = 1;
    localparam int EV_NVT  = 2;
    localparam int EV_NBIT = 3;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_STK  = 2'b01,
        ST_DONE = 2'b11
    } mmvd_stk_e;
endpackage

// File: sim/mmvd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module mmvd_cpu_model
    import mmvd_pkg::*;
(
    // clock
    input  wire logic        ref_clk,
    // memory port
    output logic      [15:0] cpuAddr,
    output logic             cpuRd,
    output logic             cpuWr,
    output logic      [7:0]  cpuWdata,
    input  wire logic [7:0]  cpuRdata,
    // stacking requests
    output logic             irqEnter,
    output logic             callEnter,
    output logic             pullByte,
    output logic      [7:0]  ctxByte,
    input  wire logic [2:0]  pushIndex
);
    // each slot gets its own byte so a repeated slot would show
    assign ctxByte = {5'h18, pushIndex};
    // idle bus at time zero
    initial begin
        {cpuAddr, cpuRd, cpuWr, cpuWdata} = '0;
        {irqEnter, callEnter, pullByte} = '0;
    end
    // one read, strobe held for one edge, data the cycle after
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        cpuAddr <= a;
        cpuRd <= 1'b1;
        @(posedge ref_clk);
        cpuRd <= 1'b0;
        #1 d = cpuRdata;
    endtask
    // one write; released data lines flip so stale values never match
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        cpuAddr <= a;
        cpuWdata <= d;
        cpuWr <= 1'b1;
        @(posedge ref_clk);
        cpuWr <= 1'b0;
        cpuWdata <= ~d;
    endtask
    // single-edge request: 0 interrupt frame, 1 call frame, 2 pull
    task automatic req(input int k);
        @(posedge ref_clk);
        irqEnter <= (k == 0);
        callEnter <= (k == 1);
        pullByte <= (k == 2);
        @(posedge ref_clk);
        {irqEnter, callEnter, pullByte} <= 3'b000;
    endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb
    import mmvd_pkg::*;
;
    logic        ref_clk, nrst, lowVoltageIndicator;
    logic [6:0]  pend;
    logic [15:0] cpuAddr, stackPtr, vectorAddr;
    logic [7:0]  cpuWdata, cpuRdata, ctxByte, vecByte;
    logic        cpuRd, cpuWr, irqEnter, callEnter, pullByte;
    logic        vecRead, pushStrobe, stackBusy, watchdogKick, irqOut;
    logic [2:0]  pushIndex;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid;
    logic [31:0] pushCnt = '0, kickCnt = '0, vecCnt = '0, slot = '0;
    int          error_cnt = 0;
    int          n_compared = 0;
    mmvd_decode dut (
        .ref_clk, .nrst, .cpuAddr, .cpuRd, .cpuWr, .cpuWdata, .cpuRdata,
        .vecRead, .vecByte, .irqEnter, .callEnter, .pullByte, .ctxByte,
        .pushStrobe, .pushIndex, .stackBusy, .stackPtr,
        .conversionDonePending(pend[0]), .keypadPending(pend[1]),
        .timerOverflowPending(pend[2]), .timerChannel1Pending(pend[3]),
        .timerChannel0Pending(pend[4]), .externalPinPending(pend[5]),
        .softwareInterrupt(pend[6]), .lowVoltageIndicator,
        .vectorAddr, .watchdogKick,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .irqOut
    );
    mmvd_cpu_model cpu (
        .ref_clk, .cpuAddr, .cpuRd, .cpuWr, .cpuWdata, .cpuRdata,
        .irqEnter, .callEnter, .pullByte, .ctxByte, .pushIndex
    );
    // vector array stand-in, byte tied to the low address bits
    assign vecByte = {2'b10, cpuAddr[5:0]};
    // 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    // push slots must run 0,1,2.. in order within a frame
    always @(posedge ref_clk) begin
        if (pushStrobe === 1'b1) begin
            chk({29'h0, pushIndex}, slot);
            slot = slot + 1;
            pushCnt = pushCnt + 1;
        end else begin
            slot = '0;
        end
    end
    // kick and vector reads counted so a stretched pulse shows as extra
    always @(posedge ref_clk) begin
        if (watchdogKick === 1'b1) kickCnt = kickCnt + 1;
        if (vecRead === 1'b1) vecCnt = vecCnt + 1;
    end
    task automatic fail(input string m);
        error_cnt++;
        $display("[ERR] %0t %s", $time, m);
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e) fail($sformatf("got %h want %h", s, e));
    endtask
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // a wait that ran out closes the run
    task automatic hang(input bit ok);
        if (!ok) begin
            fail("timeout");
            wrap_up();
        end
    endtask
    task automatic do_reset();
        nrst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        repeat (2) @(posedge ref_clk);
    endtask
    // address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          output logic [1:0] r);
        bit aw;
        bit w;
        int i;
        aw = 0;
        w = 0;
        @(posedge ref_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (i = 0; i < 50 && !(aw && w); i++) begin
            @(posedge ref_clk);
            aw = aw || s_axi_awready === 1'b1;
            w = w || s_axi_wready === 1'b1;
            s_axi_awvalid <= !aw;
            s_axi_wvalid <= !w;
        end
        hang(aw && w);
        for (i = 0; i < 50 && s_axi_bvalid !== 1'b1; i++) @(posedge ref_clk);
        hang(s_axi_bvalid === 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                          output logic [1:0] r);
        int i;
        @(posedge ref_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (s_axi_arready === 1'b1) break;
        end
        hang(i < 50);
        s_axi_arvalid <= 1'b0;
        for (i = 0; i < 50 && s_axi_rvalid !== 1'b1; i++) @(posedge ref_clk);
        hang(s_axi_rvalid === 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic axi_chk(input logic [7:0] a, input logic [31:0] e,
                           input logic [1:0] er);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic cpu_chk(input logic [15:0] a, input logic [7:0] e);
        logic [7:0] d;
        cpu.rd(a, d);
        chk({24'h0, d}, {24'h0, e});
    endtask
    task automatic wait_idle();
        int i;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            #1;
            if (stackBusy === 1'b0) break;
        end
        hang(i < 40);
    endtask
    // reset values, unmapped access, trim defaults
    task automatic t_regs();
        logic [1:0] r;
        axi_chk(AX_STATUS, 32'h0, 2'b00);
        axi_chk(AX_SPREG, {16'h0, SP_RST}, 2'b00);
        axi_chk(AX_TRIM, {16'h0, TRIM_DFLT, TRIM_DFLT}, 2'b00);
        axi_chk(AX_WDOG, 32'h0, 2'b00);
        axi_chk(8'h20, 32'h0, 2'b10);
        axi_wr(8'h20, 32'h5a5a_5a5a, r);
        chk({30'h0, r}, 32'h2);
        for (int k = 8; k <= 12; k++) cpu_chk(16'hfe00 + 16'(k), 8'h00);
        cpu_chk(TRIM5_ADDR, TRIM_DFLT);
        cpu_chk(TRIM3_ADDR, TRIM_DFLT);
        chk({16'h0, stackPtr}, {16'h0, SP_RST});
    endtask
    task automatic t_ram();
        cpu.wr(RAM_LO, 8'h3c);
        cpu.wr(RAM_HI, 8'hc3);
        cpu_chk(RAM_LO, 8'h3c);
        cpu_chk(RAM_HI, 8'hc3);
    endtask
    task automatic t_stack();
        logic [1:0] r;
        logic [31:0] p0;
        axi_wr(AX_SPREG, 32'h0000_f00d, r);
        axi_chk(AX_SPREG, 32'h0000_f00d, 2'b00);
        axi_wr(AX_SPREG, 32'h0000_00f0, r);
        p0 = pushCnt;
        cpu.req(0);
        wait_idle();
        chk(pushCnt - p0, 32'd5);
        chk({16'h0, stackPtr}, 32'h00eb);
        cpu_chk(16'h00f0, 8'hc0);
        cpu_chk(16'h00ec, 8'hc4);
        p0 = pushCnt;
        cpu.req(1);
        wait_idle();
        chk(pushCnt - p0, 32'd2);
        chk({16'h0, stackPtr}, 32'h00e9);
        cpu.req(2);
        wait_idle();
        chk({16'h0, stackPtr}, 32'h00ea);
        axi_chk(AX_STATUS, 32'h2, 2'b00);
    endtask
    // raise pending lines lowest first; each new one must win
    task automatic t_vec();
        logic [15:0] vt [7];
        vt = '{VEC_ADC, VEC_KBD, VEC_TOV, VEC_TC1, VEC_TC0, VEC_EXT, VEC_SWI};
        chk({16'h0, vectorAddr}, {16'h0, VEC_RST});
        for (int k = 0; k < 7; k++) begin
            @(posedge ref_clk);
            pend[k] <= 1'b1;
            @(posedge ref_clk);
            #1 chk({16'h0, vectorAddr}, {16'h0, vt[k]});
        end
        axi_chk(AX_VECSEL, {16'h0, VEC_SWI}, 2'b00);
        axi_chk(AX_PEND, 32'h0001_8074, 2'b00);
        cpu_chk(INT1_ADDR, 8'h74);
        cpu_chk(INT2_ADDR, 8'h80);
        cpu_chk(INT3_ADDR, 8'h01);
        cpu.wr(INT1_ADDR, 8'h00);
        cpu_chk(INT1_ADDR, 8'h74);
        pend <= '0;
        cpu_chk(INT1_ADDR, 8'h00);
        cpu_chk(VEC_ADC, 8'h9e);
    endtask
    task automatic t_kick();
        logic [31:0] k0, v0;
        k0 = kickCnt;
        v0 = vecCnt;
        cpu.wr(RAM_LO, 8'h11);
        cpu.wr(WDOG_ADDR, 8'h00);
        cpu.wr(WDOG_ADDR, 8'ha5);
        #1 chk(kickCnt - k0, 32'd2);
        cpu_chk(WDOG_ADDR, 8'hbf);
        chk(vecCnt - v0, 32'd1);
        axi_chk(AX_STATUS, 32'h3, 2'b00);
    endtask
    // test window flags an event; interrupt raised, masked, cleared
    task automatic t_irq();
        logic [1:0] r;
        axi_wr(AX_CLEAR, 32'h7, r);
        axi_wr(AX_ENABLE, 32'h4, r);
        chk({31'h0, irqOut}, 32'h0);
        axi_chk(AX_ENABLE, 32'h4, 2'b00);
        cpu.wr(NVPC_ADDR, 8'hff);
        cpu.wr(NVT_LO, 8'h55);
        cpu.wr(NVT_HI, 8'haa);
        cpu_chk(NVT_LO, 8'h00);
        cpu_chk(NVT_HI, 8'h00);
        cpu_chk(NVPC_ADDR, NVPC_MASK);
        axi_chk(AX_STATUS, 32'h4, 2'b00);
        chk({31'h0, irqOut}, 32'h1);
        axi_wr(AX_ENABLE, 32'h0, r);
        chk({31'h0, irqOut}, 32'h0);
        axi_wr(AX_ENABLE, 32'h4, r);
        chk({31'h0, irqOut}, 32'h1);
        axi_wr(AX_CLEAR, 32'h4, r);
        chk({31'h0, irqOut}, 32'h0);
        axi_chk(AX_STATUS, 32'h0, 2'b00);
        lowVoltageIndicator <= 1'b1;
        cpu_chk(LVS_ADDR, 8'h80);
    endtask
    // second reset mid-run: trim bytes keep their values
    task automatic t_after();
        logic [1:0] r;
        axi_wr(AX_TRIM, 32'h0000_3c5a, r);
        do_reset();
        axi_chk(AX_TRIM, 32'h0000_3c5a, 2'b00);
        cpu_chk(TRIM3_ADDR, 8'h3c);
        chk({16'h0, stackPtr}, {16'h0, SP_RST});
        axi_chk(AX_STATUS, 32'h0, 2'b00);
    endtask
    // main sequence
    initial begin
        {nrst, lowVoltageIndicator, pend} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'hf;
        do_reset();
        t_regs();
        t_ram();
        t_stack();
        t_vec();
        t_kick();
        t_irq();
        t_after();
        wrap_up();
    end
endmodule
`default_nettype wire
